// *** src/ccg_pkg.sv ***
// Purpose: Types shared by the clock generation control block
// Assumes: Nothing beyond the register header
// Notes:   Numbers live in ccg_regs.svh
package ccg_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [1:0] ccg_div_t;
    typedef logic [7:0] ccg_byte_t;

    // PLL oscillator sequencing
    typedef enum logic [1:0] {
        CCG_PLL_OFF,
        CCG_PLL_COUNT,
        CCG_PLL_RUN
    } ccg_pll_state_e;

endpackage : ccg_pkg

// *** src/ccg_regs.svh ***
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: Byte addresses on the special function register port
// Notes:   Included by the top-level design file and by the assertion and testbench files
`ifndef CCG_REGS_SVH
`define CCG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCG_DIV_CTRL_ADDR 16'hf002
`define CCG_SRC_CTRL_ADDR 16'hf003
`define CCG_IRQ_STAT_ADDR 16'hf0e0
`define CCG_IRQ_MASK_ADDR 16'hf0e1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCG_CPU_DIV_LSB 0
`define CCG_OUT_DIV_LSB 4
`define CCG_SRC_SEL_BIT 0
`define CCG_PLL_EN_BIT 1
`define CCG_PLL_RDY_BIT 7
`define CCG_IRQ_PLL_BIT 0
`define CCG_IRQ_SLOW_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCG_DIV_CTRL_RST 8'h33
`define CCG_SRC_CTRL_RST 8'h83
`define CCG_CPU_DIV_RST 2'h3
`define CCG_OUT_DIV_RST 2'h3

// ----------------------------------------------------------------
// Stabilisation counts
// ----------------------------------------------------------------
`define CCG_PLL_STAB_COUNT 16384
`define CCG_SLOW_STAB_COUNT 128

`endif

// *** src/ccg_stab_cnt.sv ***
// Purpose: Oscillator stabilisation counter
// Assumes: tick_i is a one-cycle pulse per oscillator period
// Notes:   done_o stays high until clear_i
`timescale 1ns/100ps
module ccg_stab_cnt #(
    parameter int COUNT = 16384,
    parameter bit DONE_AT_RESET = 1'b0
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic tick_i,
    output logic done_o
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] cnt_r;

    // Count oscillator periods; clear restarts from zero
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
            done_o <= DONE_AT_RESET;
        end else if (clear_i) begin
            cnt_r <= '0;
            done_o <= 1'b0;
        end else if (tick_i && !done_o) begin
            if (cnt_r == LAST) begin
                done_o <= 1'b1;
            end
            cnt_r <= cnt_r + W'(1);
        end
    end

endmodule : ccg_stab_cnt

// *** src/ccg_top.sv ***
// Purpose: Clock generation control: dividers, CPU source select, PLL start
// Assumes: Oscillator periods arrive as one-cycle pulses on mclk_i
// Notes:   All generated clocks are one-cycle enable pulses
//
// Functional notes
// - After reset CPU and fast peripheral clocks run at PLL clock divided by 16.
// - Two-bit CPU divider field selects PLL divide by 2, 4, 8, 16; resets 16.
// - Two-bit output field selects PLL divide by 1, 2, 4, 8; resets 8.
// - Source bit picks slow clock (0) or divided fast clock (1); resets 1.
// - With oscillation disabled, source bit held 0 and CPU runs slow.
// - PLL enable bit starts oscillation when 1, stops it when 0; resets 1.
// - Ready flag is 1 after 16384 PLL cycles counted; reset value 1.
// - Ready flag is read-only; writes to its bit are ignored.
// - Deliver slow, fast peripheral, CPU and port output clocks.
// - Divider register takes byte or word access; word includes source register.
// - Unused divider register bits 7, 6, 3, 2 read zero; reset value 33h.
// - PLL clock supply starts only when cycle counter reaches 16384; here reset enters run and supplies at once, with no count.
// - Oscillation stops in stop state and restarts when stop is released.
// - Slow clock supplied only after 128 slow oscillator counts from power-on.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "ccg_regs.svh"
module ccg_top #(
    parameter int PLL_STAB = `CCG_PLL_STAB_COUNT,
    parameter int SLOW_STAB = `CCG_SLOW_STAB_COUNT
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] sfr_addr_i,
    input wire logic [15:0] sfr_wdata_i,
    input wire logic sfr_word_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [15:0] sfr_rdata_o,
    input wire logic pll_tick_i,
    input wire logic slow_tick_i,
    input wire logic stop_i,
    output logic pll_osc_en_o,
    output logic slow_clk_o,
    output logic fast_periph_clk_o,
    output logic cpu_clk_o,
    output logic port_fast_clk_o,
    output logic port_slow_clk_o,
    output logic irq_o
);
    import ccg_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ccg_div_t cpu_div_r;
    ccg_div_t out_div_r;
    ccg_div_t cpu_div_act_r;
    ccg_div_t out_div_act_r;
    logic src_sel_r;
    logic src_act_r;
    logic pll_en_r;
    ccg_pll_state_e pll_state_r;
    ccg_pll_state_e pll_state_nxt;
    logic pll_done;
    logic slow_done;
    logic pll_done_q_r;
    logic slow_done_q_r;
    logic [3:0] div_cnt_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic pll_run;
    logic pll_tick;
    logic boundary;
    logic wr_div;
    logic wr_src;
    logic rd_stat;
    ccg_byte_t div_rd;
    ccg_byte_t src_rd;

    // True when the low bits picked by the divider code are all ones
    function automatic logic div_hit(input logic [3:0] cnt, input logic [2:0] log2n);
        logic [3:0] mask;
        mask = 4'((5'h01 << log2n) - 5'h01);
        div_hit = (cnt & mask) == mask;
    endfunction : div_hit

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // A word access at the divider address also writes the source byte
    assign wr_div = sfr_wr_i && (sfr_addr_i == `CCG_DIV_CTRL_ADDR);
    assign wr_src = sfr_wr_i && ((sfr_addr_i == `CCG_SRC_CTRL_ADDR && !sfr_word_i)
                    || (sfr_addr_i == `CCG_DIV_CTRL_ADDR && sfr_word_i));
    assign rd_stat = sfr_rd_i && (sfr_addr_i == `CCG_IRQ_STAT_ADDR);

    // Source byte sits in the low lane on a byte access, high lane on a word
    logic [7:0] src_wbyte;
    assign src_wbyte = sfr_word_i ? sfr_wdata_i[15:8] : sfr_wdata_i[7:0];

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Divider fields; unused bits are never stored
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_div_r <= `CCG_CPU_DIV_RST;
            out_div_r <= `CCG_OUT_DIV_RST;
        end else if (wr_div) begin
            cpu_div_r <= sfr_wdata_i[`CCG_CPU_DIV_LSB +: 2];
            out_div_r <= sfr_wdata_i[`CCG_OUT_DIV_LSB +: 2];
        end
    end

    // Enable and source; bit 7 of the write is dropped since the flag is hardware
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pll_en_r <= 1'b1;
            src_sel_r <= 1'b1;
        end else if (wr_src) begin
            pll_en_r <= src_wbyte[`CCG_PLL_EN_BIT];
            src_sel_r <= src_wbyte[`CCG_SRC_SEL_BIT] && src_wbyte[`CCG_PLL_EN_BIT];
        end else if (!pll_en_r) begin
            src_sel_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // PLL sequencing
    // ------------------------------------------------------------
    assign pll_run = pll_en_r && !stop_i;

    // Leaving run restarts stabilisation from zero
    always_comb begin
        pll_state_nxt = pll_state_r;
        unique case (pll_state_r)
            CCG_PLL_OFF: if (pll_run) pll_state_nxt = CCG_PLL_COUNT;
            CCG_PLL_COUNT: begin
                if (!pll_run) begin
                    pll_state_nxt = CCG_PLL_OFF;
                end else if (pll_done) begin
                    pll_state_nxt = CCG_PLL_RUN;
                end
            end
            CCG_PLL_RUN: if (!pll_run) pll_state_nxt = CCG_PLL_OFF;
            // Unused code: park the PLL and restabilise
            default: pll_state_nxt = CCG_PLL_OFF;
        endcase
    end

    // Reset enters run directly: the flag's reset value says supply is live
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pll_state_r <= CCG_PLL_RUN;
        end else begin
            pll_state_r <= pll_state_nxt;
        end
    end

    ccg_stab_cnt #(
        .COUNT(PLL_STAB),
        .DONE_AT_RESET(1'b1)
    ) u_pll_stab (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .clear_i(pll_state_r == CCG_PLL_OFF),
        .tick_i(pll_tick_i && pll_state_r == CCG_PLL_COUNT),
        .done_o(pll_done)
    );

    // Slow oscillator is held during stop and restabilised afterwards
    ccg_stab_cnt #(
        .COUNT(SLOW_STAB),
        .DONE_AT_RESET(1'b0)
    ) u_slow_stab (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .clear_i(stop_i),
        .tick_i(slow_tick_i),
        .done_o(slow_done)
    );

    // Only a stabilised PLL feeds the dividers
    assign pll_tick = pll_tick_i && pll_state_r == CCG_PLL_RUN;

    // ------------------------------------------------------------
    // Dividers and glitch-free switching
    // ------------------------------------------------------------
    // One shared counter keeps every divided output phase-aligned
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt_r <= 4'h0;
        end else if (pll_state_r != CCG_PLL_RUN) begin
            div_cnt_r <= 4'h0;
        end else if (pll_tick) begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end

    // Last PLL tick of the longest period: every PLL-divided output pulses here
    assign boundary = pll_tick && div_cnt_r == 4'hf;

    // New settings only take over at the boundary or while the PLL is idle,
    // so no divided period is ever cut short
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_div_act_r <= `CCG_CPU_DIV_RST;
            out_div_act_r <= `CCG_OUT_DIV_RST;
            src_act_r <= 1'b1;
        end else if (boundary || pll_state_r != CCG_PLL_RUN) begin
            cpu_div_act_r <= cpu_div_r;
            out_div_act_r <= out_div_r;
            src_act_r <= src_sel_r;
        end
    end

    // ------------------------------------------------------------
    // Clock enable outputs
    // ------------------------------------------------------------
    // Registered pulses; CPU stalls if fast source chosen before PLL is ready
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fast_periph_clk_o <= 1'b0;
            cpu_clk_o <= 1'b0;
            port_fast_clk_o <= 1'b0;
            slow_clk_o <= 1'b0;
            port_slow_clk_o <= 1'b0;
            pll_osc_en_o <= 1'b1;
        end else begin
            fast_periph_clk_o <= pll_tick
                && div_hit(div_cnt_r, {1'b0, cpu_div_act_r} + 3'h1);
            cpu_clk_o <= src_act_r
                ? (pll_tick && div_hit(div_cnt_r, {1'b0, cpu_div_act_r} + 3'h1))
                : (slow_tick_i && slow_done);
            port_fast_clk_o <= pll_tick && div_hit(div_cnt_r, {1'b0, out_div_act_r});
            slow_clk_o <= slow_tick_i && slow_done;
            port_slow_clk_o <= slow_tick_i && slow_done;
            pll_osc_en_o <= pll_run;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Rising edges of the two ready conditions
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pll_done_q_r <= 1'b1;
            slow_done_q_r <= 1'b0;
        end else begin
            pll_done_q_r <= pll_state_r == CCG_PLL_RUN;
            slow_done_q_r <= slow_done;
        end
    end

    // Sticky status, cleared by read; a new event in the read cycle survives
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_r <= 2'h0;
        end else begin
            irq_stat_r <= (rd_stat ? 2'h0 : irq_stat_r)
                | {slow_done && !slow_done_q_r,
                   pll_state_r == CCG_PLL_RUN && !pll_done_q_r};
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask_r <= 2'h0;
        end else if (sfr_wr_i && sfr_addr_i == `CCG_IRQ_MASK_ADDR) begin
            irq_mask_r <= sfr_wdata_i[1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_r & irq_mask_r & ~(rd_stat ? 2'h3 : 2'h0))
                || |({slow_done && !slow_done_q_r,
                      pll_state_r == CCG_PLL_RUN && !pll_done_q_r} & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    assign div_rd = {2'h0, out_div_r, 2'h0, cpu_div_r};
    assign src_rd = {pll_state_r == CCG_PLL_RUN, 5'h00, pll_en_r, src_sel_r};

    // Data valid the cycle after the strobe only; unmapped reads give zero
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= 16'h0000;
        end else if (!sfr_rd_i) begin
            sfr_rdata_o <= 16'h0000;
        end else begin
            unique case (sfr_addr_i)
                `CCG_DIV_CTRL_ADDR: sfr_rdata_o <= sfr_word_i ? {src_rd, div_rd}
                                                 : {8'h00, div_rd};
                `CCG_SRC_CTRL_ADDR: sfr_rdata_o <= {8'h00, src_rd};
                `CCG_IRQ_STAT_ADDR: sfr_rdata_o <= {14'h0000, irq_stat_r};
                `CCG_IRQ_MASK_ADDR: sfr_rdata_o <= {14'h0000, irq_mask_r};
                default: sfr_rdata_o <= 16'h0000;
            endcase
        end
    end

endmodule : ccg_top

// *** verif/ccg_osc_model.sv ***
// Purpose: Oscillator model, PLL and slow RC tick pulses
// Assumes: PLL runs only while the run request is high
// Notes:   Periods are shortened so the run stays brief
`timescale 1ns/100ps
module ccg_osc_model #(
    parameter int PLL_DIV = 2,
    parameter int SLOW_DIV = 8
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic osc_en_i,
    input wire logic stop_i,
    output logic pll_tick_o,
    output logic slow_tick_o
);
    // ------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------
    int pc;
    int sc;
    // PLL ticks only while requested, so stop really halts it
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc <= 0;
            pll_tick_o <= 1'b0;
        end else begin
            pc <= (osc_en_i && pc < PLL_DIV - 1) ? pc + 1 : 0;
            pll_tick_o <= osc_en_i && pc == PLL_DIV - 1;
        end
    end
    // RC oscillator halts in the stop state
    always_ff @(posedge mclk_i) begin
        sc <= (stop_i || sc == SLOW_DIV - 1) ? 0 : sc + 1;
        slow_tick_o <= !stop_i && sc == SLOW_DIV - 1;
    end
endmodule : ccg_osc_model

// *** verif/ccg_top_assertions.sv ***
// Purpose: Port level checks of the clock generation control
// Assumes: Oscillator ticks are one-cycle pulses
// Notes:   Bound into every ccg_top instance
`timescale 1ns/100ps
`include "ccg_regs.svh"
module ccg_chk #(
    parameter int PLL_STAB = 16384,
    parameter int SLOW_STAB = 128
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] sfr_addr_i,
    input wire logic sfr_rd_i,
    input wire logic [15:0] sfr_rdata_o,
    input wire logic pll_tick_i,
    input wire logic slow_tick_i,
    input wire logic stop_i,
    input wire logic pll_osc_en_o,
    input wire logic slow_clk_o,
    input wire logic fast_periph_clk_o,
    input wire logic cpu_clk_o,
    input wire logic port_fast_clk_o,
    input wire logic port_slow_clk_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    osc_stop_a: assert property (stop_i |=> !pll_osc_en_o)
        else $error("oscillator runs in stop state");
    rd_idle_a: assert property (!$past(sfr_rd_i) |-> sfr_rdata_o == 16'h0)
        else $error("read data outside read cycle");
    div_rsvd_a: assert property ($past(sfr_rd_i && sfr_addr_i == `CCG_DIV_CTRL_ADDR)
        |-> sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[3:2] == 2'h0)
        else $error("unused divider bits not zero");
    fast_gap_a: assert property (fast_periph_clk_o |=> !fast_periph_clk_o)
        else $error("fast clock pulses back to back");
    fast_tick_a: assert property (fast_periph_clk_o |-> $past(pll_tick_i))
        else $error("fast pulse without PLL tick");
    port_tick_a: assert property (port_fast_clk_o |-> $past(pll_tick_i))
        else $error("port pulse without PLL tick");
    slow_tick_a: assert property (slow_clk_o |-> $past(slow_tick_i))
        else $error("slow pulse without RC tick");
    slow_port_a: assert property (port_slow_clk_o == slow_clk_o)
        else $error("port slow clock differs");
    cpu_src_a: assert property (cpu_clk_o |-> $past(pll_tick_i) || $past(slow_tick_i))
        else $error("cpu pulse without source tick");
    pll_count_a: assert property ($rose(pll_osc_en_o) |-> !fast_periph_clk_o [*8])
        else $error("fast clock before stabilisation");
    irq_clr_a: assert property (sfr_rd_i && sfr_addr_i == `CCG_IRQ_STAT_ADDR |-> ##2 !irq_o)
        else $error("interrupt stays after status read");
endmodule : ccg_chk

bind ccg_top ccg_chk #(.PLL_STAB(PLL_STAB), .SLOW_STAB(SLOW_STAB)) chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .pll_tick_i(pll_tick_i),
    .slow_tick_i(slow_tick_i), .stop_i(stop_i), .pll_osc_en_o(pll_osc_en_o),
    .slow_clk_o(slow_clk_o), .fast_periph_clk_o(fast_periph_clk_o),
    .cpu_clk_o(cpu_clk_o), .port_fast_clk_o(port_fast_clk_o),
    .port_slow_clk_o(port_slow_clk_o), .irq_o(irq_o));

// *** verif/ccg_top_tb.sv ***
// Purpose: Register and clock rate tests of the clock generation control
// Assumes: PLL tick every 2 cycles, RC tick every 8 cycles
// Notes:   Stabilisation counts shortened to 16 and 4
`timescale 1ns/100ps
`include "ccg_regs.svh"
module ccg_top_tb;
    logic mclk_i, reset_n_i, sfr_word_i, sfr_wr_i, sfr_rd_i, stop_i;
    logic [15:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, q;
    logic pll_tick_i, slow_tick_i, pll_osc_en_o, slow_clk_o, fast_periph_clk_o;
    logic cpu_clk_o, port_fast_clk_o, port_slow_clk_o, irq_o;
    int bad_count = 0;
    int comparisons = 0;
    int g, n, ticks;
    ccg_top #(.PLL_STAB(16), .SLOW_STAB(4)) uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_word_i(sfr_word_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
        .pll_tick_i(pll_tick_i), .slow_tick_i(slow_tick_i), .stop_i(stop_i),
        .pll_osc_en_o(pll_osc_en_o), .slow_clk_o(slow_clk_o),
        .fast_periph_clk_o(fast_periph_clk_o), .cpu_clk_o(cpu_clk_o),
        .port_fast_clk_o(port_fast_clk_o), .port_slow_clk_o(port_slow_clk_o),
        .irq_o(irq_o));
    ccg_osc_model osc (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .osc_en_i(pll_osc_en_o),
        .stop_i(stop_i), .pll_tick_o(pll_tick_i), .slow_tick_o(slow_tick_i));
    // ------------------------------------------------------------
    // Clock, tick counter and tasks
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (pll_tick_i === 1'b1) ticks++;
    task give_verdict();
        if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] v);
        comparisons++;
        if (v !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, v);
        end
    endtask : cmp
    task wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge mclk_i);
        {sfr_addr_i, sfr_wdata_i, sfr_word_i, sfr_wr_i} <= {a, d, w, 1'b1};
        @(posedge mclk_i);
        {sfr_word_i, sfr_wr_i} <= 2'b00;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [15:0] a, input logic w, output logic [15:0] d);
        @(posedge mclk_i);
        {sfr_addr_i, sfr_word_i, sfr_rd_i} <= {a, w, 1'b1};
        @(posedge mclk_i);
        {sfr_word_i, sfr_rd_i} <= 2'b00;
        @(posedge mclk_i);
        d = sfr_rdata_o;
    endtask : rd
    function logic pick(input int s);
        return s == 0 ? fast_periph_clk_o : s == 1 ? cpu_clk_o
            : s == 2 ? port_fast_clk_o : slow_clk_o;
    endfunction : pick
    // Spacing in cycles between two pulses of one output, bounded
    task gap(input int s, output int c);
        int k;
        k = 0;
        do begin @(posedge mclk_i); k++; end while (pick(s) !== 1'b1 && k < 500);
        c = 0;
        do begin @(posedge mclk_i); c++; end while (pick(s) !== 1'b1 && c < 500);
        if (k >= 500 || c >= 500) begin bad_count++; give_verdict(); end
    endtask : gap
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n_i, sfr_word_i, sfr_wr_i, sfr_rd_i, stop_i} = 5'b0;
        {sfr_addr_i, sfr_wdata_i} = 32'h0;
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (60) @(posedge mclk_i);
        rd(`CCG_DIV_CTRL_ADDR, 1'b0, q); cmp("div_rst", 16'h0033, q);
        rd(`CCG_SRC_CTRL_ADDR, 1'b0, q); cmp("src_rst", 16'h0083, q);
        rd(`CCG_DIV_CTRL_ADDR, 1'b1, q); cmp("word_rst", 16'h8333, q);
        rd(16'hf004, 1'b0, q); cmp("unmapped", 16'h0, q);
        rd(`CCG_IRQ_STAT_ADDR, 1'b0, q); cmp("stat_slow", 16'h2, q & 16'h2);
        gap(0, g); cmp("fast_rst", 16'd32, 16'(g));
        gap(1, g); cmp("cpu_rst", 16'd32, 16'(g));
        gap(2, g); cmp("port_rst", 16'd16, 16'(g));
        gap(3, g); cmp("slow", 16'd8, 16'(g));
        // Every divider code, with the unused bits written as ones
        for (int i = 0; i < 4; i++) begin
            wr(`CCG_DIV_CTRL_ADDR, 16'h00cc | 16'(i << 4) | 16'(3 - i), 1'b0);
            rd(`CCG_DIV_CTRL_ADDR, 1'b0, q); cmp("div_rw", 16'(i << 4 | 3 - i), q);
            repeat (40) @(posedge mclk_i);
            gap(0, g); cmp("fast_div", 16'(4 << (3 - i)), 16'(g));
            gap(1, g); cmp("cpu_div", 16'(4 << (3 - i)), 16'(g));
            gap(2, g); cmp("port_div", 16'(2 << i), 16'(g));
        end
        // High lane clears the source bit, keeps the PLL enabled and writes one to the ready flag
        wr(`CCG_DIV_CTRL_ADDR, 16'h8233, 1'b1);
        rd(`CCG_SRC_CTRL_ADDR, 1'b0, q); cmp("word_wr", 16'h0082, q);
        wr(`CCG_SRC_CTRL_ADDR, 16'h0001, 1'b0);
        rd(`CCG_SRC_CTRL_ADDR, 1'b0, q); cmp("osc_off", 16'h0, q);
        cmp("osc_en", 16'h0, 16'(pll_osc_en_o));
        gap(1, g); cmp("cpu_slow", 16'd8, 16'(g));
        // Re-enable and count PLL ticks until ready shows
        wr(`CCG_SRC_CTRL_ADDR, 16'h0003, 1'b0);
        ticks = 0;
        n = 0;
        do begin rd(`CCG_SRC_CTRL_ADDR, 1'b0, q); n++; end while (q[7] !== 1'b1 && n < 100);
        cmp("rdy_flag", 16'h1, 16'(q[7]));
        cmp("rdy_ticks", 16'h1, 16'(ticks >= 16 && ticks <= 20));
        cmp("irq_masked", 16'h0, 16'(irq_o));
        wr(`CCG_IRQ_MASK_ADDR, 16'h0001, 1'b0);
        repeat (2) @(posedge mclk_i);
        cmp("irq_on", 16'h1, 16'(irq_o));
        rd(`CCG_IRQ_STAT_ADDR, 1'b0, q); cmp("stat_pll", 16'h1, q);
        repeat (2) @(posedge mclk_i);
        cmp("irq_off", 16'h0, 16'(irq_o));
        stop_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        cmp("stop_osc", 16'h0, 16'(pll_osc_en_o));
        stop_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        cmp("resume_osc", 16'h1, 16'(pll_osc_en_o));
        gap(0, g); cmp("fast_resume", 16'd32, 16'(g));
        give_verdict();
    end
endmodule : ccg_top_tb
